// ===== src/lifirq_top.sv
// per-channel interrupt mask, edge select and pending logic of a line interface
// assumes status levels and event pulses arrive on clk from the detectors,
// and a register master that never issues read and write together
`timescale 1ns/1ns
module lifirq_top #(
  parameter int NCH = 4
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // live line status levels, one byte per channel
  input  wire logic [7:0] line_state [NCH],
  // counter and buffer event pulses, one byte per channel
  input  wire logic [7:0] count_event [NCH],
  // interrupt request
  output logic            irq
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // two address bits carry the channel number
  if (NCH < 1 || NCH > 4) begin : g_bad_nch
    $error("NCH must lie between 1 and 4");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]     mask_a_reg   [NCH];
  logic [7:0]     mask_a_next  [NCH];
  logic [7:0]     mask_b_reg   [NCH];
  logic [7:0]     mask_b_next  [NCH];
  logic [7:0]     edge_sel_reg [NCH];
  logic [7:0]     edge_sel_next[NCH];
  logic [7:0]     edge_map     [NCH];
  logic [7:0]     line_event   [NCH];
  logic [7:0]     src_en_a     [NCH];
  logic [7:0]     src_en_b     [NCH];
  logic [7:0]     set_a        [NCH];
  logic [7:0]     set_b        [NCH];
  logic [7:0]     clr_a        [NCH];
  logic [7:0]     clr_b        [NCH];
  logic [7:0]     pend_a       [NCH];
  logic [7:0]     pend_b       [NCH];
  logic [NCH-1:0] chan_active;
  logic [1:0]     rd_chan;
  logic [5:0]     rd_off;
  logic           rd_chan_ok;
  logic [7:0]     rd_word;
  logic [7:0]     reg_rdata_reg;
  logic [7:0]     reg_rdata_next;
  logic           irq_reg;
  logic           irq_next;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // true when the address names register off of channel ch
  function automatic logic reg_hit(input logic [7:0] addr, input int ch,
                                   input logic [5:0] off);
    logic [1:0] ch_code;
    ch_code = 2'(ch);
    return (addr[7:lifirq_pkg::CHAN_SHIFT] == ch_code) && (addr[5:0] == off);
  endfunction

  // ----------------------------------------------------------------
  // per channel logic
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch

    // register writes
    assign mask_a_next[c]   = (reg_wr && reg_hit(reg_addr, c, lifirq_pkg::OFF_IRQ_MASK_A))
                              ? reg_wdata : mask_a_reg[c];
    assign mask_b_next[c]   = (reg_wr && reg_hit(reg_addr, c, lifirq_pkg::OFF_IRQ_MASK_B))
                              ? reg_wdata : mask_b_reg[c];
    assign edge_sel_next[c] = (reg_wr && reg_hit(reg_addr, c, lifirq_pkg::OFF_EDGE_SELECT))
                              ? reg_wdata : edge_sel_reg[c];

    // write one to clear pending bits
    assign clr_a[c] = (reg_wr && reg_hit(reg_addr, c, lifirq_pkg::OFF_PEND_A))
                      ? reg_wdata : 8'h00;
    assign clr_b[c] = (reg_wr && reg_hit(reg_addr, c, lifirq_pkg::OFF_PEND_B))
                      ? reg_wdata : 8'h00;

    // edge choice per status source, same bit order as the status byte
    assign edge_map[c][lifirq_pkg::EQUALIZER_RANGE_BIT]  =
      edge_sel_reg[c][lifirq_pkg::EQUALIZER_RANGE_BIT];
    assign edge_map[c][lifirq_pkg::ACTIVATE_CODE_BIT]    =
      edge_sel_reg[c][lifirq_pkg::ACTIVATE_CODE_BIT];
    assign edge_map[c][lifirq_pkg::DEACTIVATE_CODE_BIT]  =
      edge_sel_reg[c][lifirq_pkg::DEACTIVATE_CODE_BIT];
    assign edge_map[c][lifirq_pkg::PATTERN_SYNC_BIT]     =
      edge_sel_reg[c][lifirq_pkg::PATTERN_SYNC_BIT];
    assign edge_map[c][lifirq_pkg::TX_CLOCK_LOSS_BIT]    =
      edge_sel_reg[c][lifirq_pkg::TX_CLOCK_LOSS_BIT];
    assign edge_map[c][lifirq_pkg::DRIVER_FAULT_BIT]     =
      edge_sel_reg[c][lifirq_pkg::DRIVER_FAULT_BIT];
    assign edge_map[c][lifirq_pkg::ALARM_INDICATION_BIT] =
      edge_sel_reg[c][lifirq_pkg::ALARM_INDICATION_BIT];
    assign edge_map[c][lifirq_pkg::SIGNAL_LOSS_BIT]      =
      edge_sel_reg[c][lifirq_pkg::SIGNAL_LOSS_BIT];

    // status levels become events by the chosen edge
    lifirq_edge_qual #(
      .W (8)
    ) u_edge (
      .clk         (clk),
      .rst         (rst),
      .state_lvl   (line_state[c]),
      .edge_sel    (edge_map[c]),
      .event_pulse (line_event[c])
    );

    // a source is enabled while its mask bit is 0
    assign src_en_a[c][lifirq_pkg::EQUALIZER_RANGE_BIT]  =
      ~mask_a_reg[c][lifirq_pkg::EQUALIZER_RANGE_BIT];
    assign src_en_a[c][lifirq_pkg::ACTIVATE_CODE_BIT]    =
      ~mask_a_reg[c][lifirq_pkg::ACTIVATE_CODE_BIT];
    assign src_en_a[c][lifirq_pkg::DEACTIVATE_CODE_BIT]  =
      ~mask_a_reg[c][lifirq_pkg::DEACTIVATE_CODE_BIT];
    assign src_en_a[c][lifirq_pkg::PATTERN_SYNC_BIT]     =
      ~mask_a_reg[c][lifirq_pkg::PATTERN_SYNC_BIT];
    assign src_en_a[c][lifirq_pkg::TX_CLOCK_LOSS_BIT]    =
      ~mask_a_reg[c][lifirq_pkg::TX_CLOCK_LOSS_BIT];
    assign src_en_a[c][lifirq_pkg::DRIVER_FAULT_BIT]     =
      ~mask_a_reg[c][lifirq_pkg::DRIVER_FAULT_BIT];
    assign src_en_a[c][lifirq_pkg::ALARM_INDICATION_BIT] =
      ~mask_a_reg[c][lifirq_pkg::ALARM_INDICATION_BIT];
    assign src_en_a[c][lifirq_pkg::SIGNAL_LOSS_BIT]      =
      ~mask_a_reg[c][lifirq_pkg::SIGNAL_LOSS_BIT];

    assign src_en_b[c][lifirq_pkg::SHAPER_OVERFLOW_BIT]         =
      ~mask_b_reg[c][lifirq_pkg::SHAPER_OVERFLOW_BIT];
    assign src_en_b[c][lifirq_pkg::JITTER_BUFFER_OVERFLOW_BIT]  =
      ~mask_b_reg[c][lifirq_pkg::JITTER_BUFFER_OVERFLOW_BIT];
    assign src_en_b[c][lifirq_pkg::JITTER_BUFFER_UNDERFLOW_BIT] =
      ~mask_b_reg[c][lifirq_pkg::JITTER_BUFFER_UNDERFLOW_BIT];
    assign src_en_b[c][lifirq_pkg::PATTERN_ERROR_BIT]           =
      ~mask_b_reg[c][lifirq_pkg::PATTERN_ERROR_BIT];
    assign src_en_b[c][lifirq_pkg::EXCESS_ZEROS_BIT]            =
      ~mask_b_reg[c][lifirq_pkg::EXCESS_ZEROS_BIT];
    assign src_en_b[c][lifirq_pkg::CODE_VIOLATION_BIT]          =
      ~mask_b_reg[c][lifirq_pkg::CODE_VIOLATION_BIT];
    assign src_en_b[c][lifirq_pkg::ONE_SECOND_TICK_BIT]         =
      ~mask_b_reg[c][lifirq_pkg::ONE_SECOND_TICK_BIT];
    assign src_en_b[c][lifirq_pkg::ERROR_COUNTER_OVERFLOW_BIT]  =
      ~mask_b_reg[c][lifirq_pkg::ERROR_COUNTER_OVERFLOW_BIT];

    // only enabled events reach the pending latches
    assign set_a[c] = line_event[c] & src_en_a[c];
    assign set_b[c] = count_event[c] & src_en_b[c];

    lifirq_pend_latch #(
      .W (8)
    ) u_pend_a (
      .clk      (clk),
      .rst      (rst),
      .set_bits (set_a[c]),
      .clr_bits (clr_a[c]),
      .pend     (pend_a[c])
    );

    lifirq_pend_latch #(
      .W (8)
    ) u_pend_b (
      .clk      (clk),
      .rst      (rst),
      .set_bits (set_b[c]),
      .clr_bits (clr_b[c]),
      .pend     (pend_b[c])
    );

    // channel requests while any pending bit is still unmasked
    assign chan_active[c] = |(pend_a[c] & src_en_a[c]) | |(pend_b[c] & src_en_b[c]);
  end

  // ----------------------------------------------------------------
  // control registers, all channels
  // ----------------------------------------------------------------
  // masks reset to 1, edge selects to 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        mask_a_reg[c]   <= lifirq_pkg::MASK_RESET;
        mask_b_reg[c]   <= lifirq_pkg::MASK_RESET;
        edge_sel_reg[c] <= lifirq_pkg::EDGE_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        mask_a_reg[c]   <= mask_a_next[c];
        mask_b_reg[c]   <= mask_b_next[c];
        edge_sel_reg[c] <= edge_sel_next[c];
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped offsets and absent channels read as zero
  assign rd_chan    = reg_addr[7:lifirq_pkg::CHAN_SHIFT];
  assign rd_off     = reg_addr[5:0];
  assign rd_chan_ok = (32'(rd_chan) < NCH);
  assign rd_word    = !rd_chan_ok                               ? 8'h00 :
                      (rd_off == lifirq_pkg::OFF_IRQ_MASK_A)  ? mask_a_reg[rd_chan]   :
                      (rd_off == lifirq_pkg::OFF_IRQ_MASK_B)  ? mask_b_reg[rd_chan]   :
                      (rd_off == lifirq_pkg::OFF_EDGE_SELECT) ? edge_sel_reg[rd_chan] :
                      (rd_off == lifirq_pkg::OFF_LIVE_STATUS) ? line_state[rd_chan]   :
                      (rd_off == lifirq_pkg::OFF_PEND_A)      ? pend_a[rd_chan]       :
                      (rd_off == lifirq_pkg::OFF_PEND_B)      ? pend_b[rd_chan]       :
                      8'h00;
  // data stand only in the cycle after the read strobe
  assign reg_rdata_next = reg_rd ? rd_word : 8'h00;

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  assign irq_next = |chan_active;

  // registered read data and interrupt line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_reg <= 8'h00;
      irq_reg       <= 1'b0;
    end else begin
      reg_rdata_reg <= reg_rdata_next;
      irq_reg       <= irq_next;
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign irq       = irq_reg;

  // ----------------------------------------------------------------
  // assertions on channel 0
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  wire clr_a0_bit0 = reg_wr && reg_hit(reg_addr, 0, lifirq_pkg::OFF_PEND_A) && reg_wdata[0];

  mask_reset_a: assert property ($past(rst) |->
                  (mask_a_reg[0] == lifirq_pkg::MASK_RESET) &&
                  (mask_b_reg[0] == lifirq_pkg::MASK_RESET) &&
                  (edge_sel_reg[0] == lifirq_pkg::EDGE_RESET) && !irq)
    else $error("control registers not at reset values");

  rise_sets_a: assert property ((!mask_a_reg[0][0] && $rose(line_state[0][0]))
                  |=> pend_a[0][0])
    else $error("unmasked rise did not latch pending");

  fall_ignored_a: assert property ((!edge_sel_reg[0][0] && $fell(line_state[0][0])
                  && !pend_a[0][0]) |=> !pend_a[0][0])
    else $error("fall latched pending in rise-only mode");

  fall_counts_a: assert property ((edge_sel_reg[0][0] && !mask_a_reg[0][0]
                  && $fell(line_state[0][0])) |=> pend_a[0][0])
    else $error("fall not latched in any-change mode");

  mask_blocks_a: assert property ((mask_a_reg[0][0] && !pend_a[0][0])
                  |=> !pend_a[0][0])
    else $error("masked source latched pending");

  count_event_a: assert property ((!mask_b_reg[0][0] && count_event[0][0])
                  |=> pend_b[0][0])
    else $error("counter event not latched");

  set_wins_a: assert property ((clr_a0_bit0 && set_a[0][0]) |=> pend_a[0][0])
    else $error("event lost against clear");

  irq_follow_a: assert property ((pend_a[0][0] && !mask_a_reg[0][0])
                  |=> irq ##0 $past(pend_a[0][0], 1))
    else $error("interrupt not raised for pending event");

  irq_hold_a: assert property ((irq && !reg_wr) |=> irq [*2] or !$stable(mask_a_reg[0])
                  or !$stable(mask_b_reg[0]) or $changed(irq))
    else $error("interrupt dropped without software action");

  // read path
  read_mask_a: assert property (reg_rd &&
                  reg_hit(reg_addr, 0, lifirq_pkg::OFF_IRQ_MASK_A)
                  |=> reg_rdata == $past(mask_a_reg[0]))
    else $error("mask read data wrong");

  live_read_a: assert property (reg_rd &&
                  reg_hit(reg_addr, 0, lifirq_pkg::OFF_LIVE_STATUS)
                  |=> reg_rdata == $past(line_state[0]))
    else $error("live status read data wrong");

  // top bit of the line group and bottom bit of the counter group
  top_rise_a: assert property ((!mask_a_reg[0][7] && $rose(line_state[0][7]))
                  |=> pend_a[0][7])
    else $error("unmasked equalizer rise not latched");

  top_fall_a: assert property ((edge_sel_reg[0][7] && !mask_a_reg[0][7]
                  && $fell(line_state[0][7])) |=> pend_a[0][7])
    else $error("equalizer fall not latched in any-change mode");

  count_mask_a: assert property ((mask_b_reg[0][0] && !pend_b[0][0])
                  |=> !pend_b[0][0])
    else $error("masked counter event latched");

  // write one to clear
  clear_bit_a: assert property ((clr_a0_bit0 && !set_a[0][0]) |=> !pend_a[0][0])
    else $error("pending bit not cleared by write");

  irq_raised_c: cover property ($rose(irq));
  fall_latch_c: cover property (edge_sel_reg[0][0] && $fell(line_state[0][0]) ##1 pend_a[0][0]);
  clear_pend_c: cover property (pend_a[0][0] ##1 clr_a0_bit0 ##1 !pend_a[0][0]);
  count_latch_c: cover property (!mask_b_reg[0][0] && count_event[0][0] ##1 pend_b[0][0]);
  race_set_c: cover property (clr_a0_bit0 && set_a[0][0]);

endmodule

// ===== src/lifirq_pkg.sv
// constants of the per-channel interrupt mask and edge select block
// assumes an 8-bit register port, channel n at byte base n*0x40
package lifirq_pkg;

  // ----------------------------------------------------------------
  // register map inside one channel window
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_IRQ_MASK_A   = 6'h11; // channel_irq_mask_a
  localparam logic [5:0] OFF_IRQ_MASK_B   = 6'h12; // channel_irq_mask_b
  localparam logic [5:0] OFF_EDGE_SELECT  = 6'h13; // irq_edge_select
  localparam logic [5:0] OFF_LIVE_STATUS  = 6'h14; // live_line_status_reg, read only
  localparam logic [5:0] OFF_PEND_A       = 6'h18; // pending line events, write 1 to clear
  localparam logic [5:0] OFF_PEND_B       = 6'h19; // pending counter events, write 1 to clear
  localparam int         CHAN_SHIFT       = 6;     // channel number sits in address bits 7:6

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_RESET       = 8'hFF; // every source masked
  localparam logic [7:0] EDGE_RESET       = 8'h00; // rising edge only
  localparam logic [7:0] PEND_RESET       = 8'h00;

  // ----------------------------------------------------------------
  // bit positions, line status group (mask a, edge select, status)
  // ----------------------------------------------------------------
  localparam int EQUALIZER_RANGE_BIT   = 7;
  localparam int ACTIVATE_CODE_BIT     = 6;
  localparam int DEACTIVATE_CODE_BIT   = 5;
  localparam int PATTERN_SYNC_BIT      = 4;
  localparam int TX_CLOCK_LOSS_BIT     = 3;
  localparam int DRIVER_FAULT_BIT      = 2;
  localparam int ALARM_INDICATION_BIT  = 1;
  localparam int SIGNAL_LOSS_BIT       = 0;

  // ----------------------------------------------------------------
  // bit positions, counter and buffer event group (mask b)
  // ----------------------------------------------------------------
  localparam int SHAPER_OVERFLOW_BIT         = 7;
  localparam int JITTER_BUFFER_OVERFLOW_BIT  = 6;
  localparam int JITTER_BUFFER_UNDERFLOW_BIT = 5;
  localparam int PATTERN_ERROR_BIT           = 4;
  localparam int EXCESS_ZEROS_BIT            = 3;
  localparam int CODE_VIOLATION_BIT          = 2;
  localparam int ONE_SECOND_TICK_BIT         = 1;
  localparam int ERROR_COUNTER_OVERFLOW_BIT  = 0;

endpackage

// ===== src/lifirq_edge_qual.sv
// edge qualifier: turns live status levels into one-cycle events
// assumes status levels come from logic on the same clock
`timescale 1ns/1ns
module lifirq_edge_qual #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // status levels and per-bit edge choice
  input  wire logic [W-1:0] state_lvl,
  input  wire logic [W-1:0] edge_sel,
  // qualified events
  output logic      [W-1:0] event_pulse
);

  // a zero-width qualifier has nothing to watch
  if (W < 1) begin : g_bad_w
    $error("W must be at least 1");
  end

  // ----------------------------------------------------------------
  // previous level
  // ----------------------------------------------------------------
  logic [W-1:0] prev_reg;
  logic [W-1:0] rise;
  logic [W-1:0] change;

  // keep last level; status resets low so a high level after reset is a rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= state_lvl;
    end
  end

  // ----------------------------------------------------------------
  // event selection
  // ----------------------------------------------------------------
  // select 0 counts a rise only, select 1 counts either change
  assign rise        = state_lvl & ~prev_reg;
  assign change      = state_lvl ^ prev_reg;
  assign event_pulse = (rise & ~edge_sel) | (change & edge_sel);

endmodule

// ===== src/lifirq_pend_latch.sv
// pending latch: sticky event bits with write-one-to-clear
// assumes set and clear are single-cycle pulses on the same clock
`timescale 1ns/1ns
module lifirq_pend_latch #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // set and clear requests
  input  wire logic [W-1:0] set_bits,
  input  wire logic [W-1:0] clr_bits,
  // latched state
  output logic      [W-1:0] pend
);

  // a zero-width latch has nothing to hold
  if (W < 1) begin : g_bad_w
    $error("W must be at least 1");
  end

  // ----------------------------------------------------------------
  // sticky storage
  // ----------------------------------------------------------------
  logic [W-1:0] pend_reg;
  logic [W-1:0] pend_next;

  // a set in the clearing cycle survives the clear
  assign pend_next = (pend_reg & ~clr_bits) | set_bits;
  assign pend      = pend_reg;

  // hold pending state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= pend_next;
    end
  end

endmodule

// ===== bench/lifirq_tb.sv
// self-checking bench of the interrupt mask, edge select and pending block
// assumes lifirq_top with four channels, driven on the rising edge of a 125 MHz clock
`timescale 1ns/1ns
module testbench;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic       clk;
  logic       rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] line_state [4];
  logic [7:0] count_event [4];
  logic       irq;
  int         n_errors;
  int         total_checks;
  int         cyc;

  lifirq_top #(.NCH(4)) uut (
    .clk         (clk),
    .rst         (rst),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .line_state  (line_state),
    .count_event (count_event),
    .irq         (irq)
  );

  // ------------------------------------------------------------------
  // clock, timeout and verdict
  // ------------------------------------------------------------------
  // 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // register port and compare helpers
  // ------------------------------------------------------------------
  function automatic logic [7:0] ad(input int ch, input logic [5:0] off);
    return {ch[1:0], off};
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk_irq(input logic e);
    repeat (3) @(posedge clk);
    #1;
    chk("irq", {7'h00, irq}, {7'h00, e});
  endtask

  // change a line level, check the pending bit it leaves, then clear it
  task automatic ev_line(input int ch, input logic [7:0] val, input logic [7:0] exp);
    logic [7:0] d;
    @(posedge clk);
    line_state[ch] <= val;
    chk_irq(exp != 8'h00);
    rd(ad(ch, lifirq_pkg::OFF_PEND_A), d);
    chk("pend_a", d, exp);
    wr(ad(ch, lifirq_pkg::OFF_PEND_A), 8'hFF);
    chk_irq(1'b0);
  endtask

  task automatic pulse(input int ch, input logic [7:0] v);
    @(posedge clk);
    count_event[ch] <= v;
    @(posedge clk);
    count_event[ch] <= 8'h00;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  // reset values in every channel and an unmapped place
  task automatic t_reset();
    logic [7:0] d;
    for (int ch = 0; ch < 4; ch++) begin
      rd(ad(ch, lifirq_pkg::OFF_IRQ_MASK_A), d);
      chk("mask_a", d, 8'hFF);
      rd(ad(ch, lifirq_pkg::OFF_IRQ_MASK_B), d);
      chk("mask_b", d, 8'hFF);
      rd(ad(ch, lifirq_pkg::OFF_EDGE_SELECT), d);
      chk("edge_sel", d, 8'h00);
    end
    wr(ad(0, 6'h20), 8'h5A);
    rd(ad(0, 6'h20), d);
    chk("unmapped", d, 8'h00);
    chk("irq_rst", {7'h00, irq}, 8'h00);
  endtask

  // line sources: masking, rise only, any change, bit order
  task automatic t_line(input int ch);
    logic [7:0] v;
    logic [7:0] d;
    for (int b = 0; b < 8; b++) begin
      v = 8'h01 << b;
      ev_line(ch, v, 8'h00);
      ev_line(ch, 8'h00, 8'h00);
      wr(ad(ch, lifirq_pkg::OFF_IRQ_MASK_A), ~v);
      rd(ad(ch, lifirq_pkg::OFF_IRQ_MASK_A), d);
      chk("mask_a_rw", d, ~v);
      ev_line(ch, v, v);
      rd(ad(ch, lifirq_pkg::OFF_LIVE_STATUS), d);
      chk("live", d, v);
      ev_line(ch, 8'h00, 8'h00);
      wr(ad(ch, lifirq_pkg::OFF_EDGE_SELECT), v);
      rd(ad(ch, lifirq_pkg::OFF_EDGE_SELECT), d);
      chk("edge_rw", d, v);
      ev_line(ch, v, v);
      ev_line(ch, 8'h00, v);
      wr(ad(ch, lifirq_pkg::OFF_IRQ_MASK_A), 8'hFF);
      wr(ad(ch, lifirq_pkg::OFF_EDGE_SELECT), 8'h00);
    end
  endtask

  // counter sources: masking, latching, mask drops irq but keeps pending
  task automatic t_count(input int ch);
    logic [7:0] v;
    logic [7:0] d;
    for (int b = 0; b < 8; b++) begin
      v = 8'h01 << b;
      pulse(ch, v);
      chk_irq(1'b0);
      rd(ad(ch, lifirq_pkg::OFF_PEND_B), d);
      chk("pend_b_masked", d, 8'h00);
      wr(ad(ch, lifirq_pkg::OFF_IRQ_MASK_B), ~v);
      pulse(ch, v);
      chk_irq(1'b1);
      wr(ad(ch, lifirq_pkg::OFF_IRQ_MASK_B), 8'hFF);
      chk_irq(1'b0);
      rd(ad(ch, lifirq_pkg::OFF_PEND_B), d);
      chk("pend_b_kept", d, v);
      wr(ad(ch, lifirq_pkg::OFF_PEND_B), v);
      rd(ad(ch, lifirq_pkg::OFF_PEND_B), d);
      chk("pend_b_clr", d, 8'h00);
    end
  endtask

  // an event in the clearing cycle survives the clear
  task automatic t_race();
    logic [7:0] d;
    wr(ad(0, lifirq_pkg::OFF_IRQ_MASK_A), 8'hFE);
    @(posedge clk);
    line_state[0] <= 8'h01;
    reg_addr      <= ad(0, lifirq_pkg::OFF_PEND_A);
    reg_wdata     <= 8'h01;
    reg_wr        <= 1'b1;
    @(posedge clk);
    reg_wr        <= 1'b0;
    chk_irq(1'b1);
    rd(ad(0, lifirq_pkg::OFF_PEND_A), d);
    chk("pend_race", d, 8'h01);
    wr(ad(0, lifirq_pkg::OFF_PEND_A), 8'h01);
    chk_irq(1'b0);
    ev_line(0, 8'h00, 8'h00);
    wr(ad(0, lifirq_pkg::OFF_IRQ_MASK_A), 8'hFF);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    n_errors     = 0;
    total_checks = 0;
    cyc          = 0;
    rst          = 1'b1;
    reg_addr     = 8'h00;
    reg_wdata    = 8'h00;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    for (int c = 0; c < 4; c++) begin
      line_state[c]  = 8'h00;
      count_event[c] = 8'h00;
    end
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_line(0);
    t_line(3);
    t_count(3);
    t_count(1);
    t_count(0);
    t_race();
    results();
  end
endmodule
